/* File: hdl/qacsf_top.v */
// Serial frame control of a four-input 8-bit sampling converter
// Assumes pins from the host are asynchronous to clk; the analog core
// presents its finished code on core_code and reads track/chan outputs.
`include "qacsf_defines.vh"

module qacsf_top (
    clk,
    arst_n,
    frame_sel_n,
    ser_clk,
    ser_cfg_in,
    core_code,
    ser_res_out,
    ser_res_oe_n,
    track_mode,
    hold_mode,
    power_down,
    sample_strobe,
    chan_sel,
    ctl_reg
);
    input wire clk;
    input wire arst_n;
    input wire frame_sel_n;
    input wire ser_clk;
    input wire ser_cfg_in;
    input wire [`QACSF_RES_W-1:0] core_code;
    output reg ser_res_out;
    output reg ser_res_oe_n;
    output reg track_mode;
    output reg hold_mode;
    output reg power_down;
    output reg sample_strobe;
    output reg [1:0] chan_sel;
    output reg [`QACSF_CTL_W-1:0] ctl_reg;

    // --------------------------------------------------------------
    // Reset release and pin synchronisers
    // --------------------------------------------------------------
    reg [1:0] rst_sync_r;
    wire rst_n;
    reg [1:0] cs_sync_r;
    reg [1:0] sck_sync_r;
    reg [1:0] din_sync_r;
    reg cs_d_r;
    reg sck_d_r;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_r <= 2'h3;
            sck_sync_r <= 2'h0;
            din_sync_r <= 2'h0;
            cs_d_r <= 1'b1;
            sck_d_r <= 1'b0;
        end else begin
            cs_sync_r <= {cs_sync_r[0], frame_sel_n};
            sck_sync_r <= {sck_sync_r[0], ser_clk};
            din_sync_r <= {din_sync_r[0], ser_cfg_in};
            cs_d_r <= cs_sync_r[1];
            sck_d_r <= sck_sync_r[1];
        end
    end

    // --------------------------------------------------------------
    // Internal clock edges
    // --------------------------------------------------------------
    wire cs_n_s;
    wire sck_s;
    wire cs_fall;
    wire cs_rise;
    wire int_fall;
    wire int_rise;

    assign cs_n_s = cs_sync_r[1];
    assign sck_s = sck_sync_r[1];
    assign cs_fall = cs_d_r && !cs_n_s;
    assign cs_rise = !cs_d_r && cs_n_s;
    // Clock gated by select; select fall over a low clock counts as a fall
    assign int_fall = !cs_n_s && ((sck_d_r && !sck_s) || (cs_fall && !sck_s));
    assign int_rise = !cs_n_s && !cs_fall && !sck_d_r && sck_s;

    // --------------------------------------------------------------
    // Falling edge count within a conversion
    // --------------------------------------------------------------
    reg [`QACSF_CNT_W-1:0] fall_cnt_r;
    reg [`QACSF_CNT_W-1:0] fall_cnt_nxt;

    always @* begin
        fall_cnt_nxt = fall_cnt_r;
        if (cs_n_s || cs_fall) begin
            fall_cnt_nxt = {`QACSF_CNT_W{1'b0}};
        end
        if (int_fall) begin
            if (fall_cnt_r == `QACSF_FALLS_PER_CONV || cs_fall) begin
                fall_cnt_nxt = `QACSF_TRACK_FIRST;
            end else if (fall_cnt_r == {`QACSF_CNT_W{1'b0}}) begin
                fall_cnt_nxt = `QACSF_TRACK_FIRST;
            end else begin
                fall_cnt_nxt = fall_cnt_r + `QACSF_TRACK_FIRST;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fall_cnt_r <= {`QACSF_CNT_W{1'b0}};
        end else begin
            fall_cnt_r <= fall_cnt_nxt;
        end
    end

    // --------------------------------------------------------------
    // Mode outputs
    // --------------------------------------------------------------
    wire in_conv;
    assign in_conv = (fall_cnt_nxt != {`QACSF_CNT_W{1'b0}})
        && (fall_cnt_nxt != `QACSF_FALLS_PER_CONV);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            track_mode <= 1'b0;
            hold_mode <= 1'b0;
            power_down <= 1'b1;
            sample_strobe <= 1'b0;
        end else begin
            track_mode <= (fall_cnt_nxt >= `QACSF_TRACK_FIRST)
                && (fall_cnt_nxt <= `QACSF_TRACK_LAST);
            hold_mode <= (fall_cnt_nxt >= `QACSF_CAPTURE_FALL) && in_conv;
            power_down <= !in_conv;
            sample_strobe <= int_fall && (fall_cnt_nxt == `QACSF_CAPTURE_FALL);
        end
    end

    // --------------------------------------------------------------
    // Control register and channel select
    // --------------------------------------------------------------
    reg [`QACSF_CTL_W-1:0] ctl_shift_r;
    wire [`QACSF_CTL_W-1:0] ctl_shift_nxt;

    assign ctl_shift_nxt = {ctl_shift_r[`QACSF_CTL_W-2:0], din_sync_r[1]};

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_shift_r <= `QACSF_CTL_RESET;
            ctl_reg <= `QACSF_CTL_RESET;
            chan_sel <= `QACSF_CHAN_RESET;
        end else begin
            if (int_rise && fall_cnt_r >= `QACSF_TRACK_FIRST
                && fall_cnt_r <= `QACSF_CTL_LAST_RISE) begin
                ctl_shift_r <= ctl_shift_nxt;
                if (fall_cnt_r == `QACSF_CTL_LAST_RISE) begin
                    ctl_reg <= ctl_shift_nxt;
                end
            end
            // Address latched at each conversion start, so it applies one late
            if (int_fall && fall_cnt_nxt == `QACSF_TRACK_FIRST) begin
                chan_sel <= ctl_reg[`QACSF_CHAN_HI:`QACSF_CHAN_LO];
            end
        end
    end

    // --------------------------------------------------------------
    // Result path through the two-entry buffer
    // --------------------------------------------------------------
    reg push_pend_r;
    reg [`QACSF_RES_W-1:0] cap_r;
    wire buf_in_ready;
    wire buf_out_valid;
    wire [`QACSF_RES_W-1:0] buf_out_data;
    reg shift_busy_r;
    reg [`QACSF_RES_W-1:0] shreg_r;
    wire pop;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            push_pend_r <= 1'b0;
            cap_r <= {`QACSF_RES_W{1'b0}};
        end else if (cs_n_s) begin
            push_pend_r <= 1'b0;
        end else if (int_fall && fall_cnt_nxt == `QACSF_CAPTURE_FALL) begin
            push_pend_r <= 1'b1;
            cap_r <= core_code;
        end else if (buf_in_ready) begin
            push_pend_r <= 1'b0;
        end
    end

    qacsf_buf2 u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .flush(cs_n_s),
        .in_valid(push_pend_r),
        .in_ready(buf_in_ready),
        .in_data(cap_r),
        .out_valid(buf_out_valid),
        .out_ready(!shift_busy_r),
        .out_data(buf_out_data)
    );

    assign pop = buf_out_valid && !shift_busy_r;

    // --------------------------------------------------------------
    // Serial result output
    // --------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_busy_r <= 1'b0;
            shreg_r <= {`QACSF_RES_W{1'b0}};
            ser_res_out <= 1'b0;
            ser_res_oe_n <= 1'b1;
        end else begin
            ser_res_oe_n <= cs_n_s;
            if (cs_n_s || cs_rise) begin
                shift_busy_r <= 1'b0;
                ser_res_out <= 1'b0;
            end else if (pop) begin
                shift_busy_r <= 1'b1;
                shreg_r <= {buf_out_data[`QACSF_RES_W-2:0], 1'b0};
                ser_res_out <= buf_out_data[`QACSF_RES_W-1];
            end else if (int_fall && shift_busy_r) begin
                if (fall_cnt_nxt > `QACSF_MSB_FALL && fall_cnt_nxt <= `QACSF_LSB_FALL) begin
                    shreg_r <= {shreg_r[`QACSF_RES_W-2:0], 1'b0};
                    ser_res_out <= shreg_r[`QACSF_RES_W-1];
                end else if (fall_cnt_nxt > `QACSF_LSB_FALL
                    || fall_cnt_nxt < `QACSF_MSB_FALL) begin
                    shift_busy_r <= 1'b0;
                    ser_res_out <= 1'b0;
                end
            end else if (int_fall && !shift_busy_r) begin
                ser_res_out <= 1'b0;
            end
        end
    end

endmodule

/* File: hdl/qacsf_defines.vh */
// Constants for the four-input converter serial frame control
// Assumes inclusion by qacsf_top.v and qacsf_buf2.v
`ifndef QACSF_DEFINES_VH
`define QACSF_DEFINES_VH

// --------------------------------------------------------------
// Conversion frame counts, in serial clock falling edges
// --------------------------------------------------------------
`define QACSF_CNT_W 5
`define QACSF_FALLS_PER_CONV 5'h10
`define QACSF_TRACK_FIRST 5'h01
`define QACSF_TRACK_LAST 5'h03
`define QACSF_CAPTURE_FALL 5'h04
`define QACSF_MSB_FALL 5'h04
`define QACSF_LSB_FALL 5'h0b
`define QACSF_CTL_LAST_RISE 5'h08

// --------------------------------------------------------------
// Control register layout
// --------------------------------------------------------------
`define QACSF_CTL_W 8
`define QACSF_CTL_RESET 8'h00
`define QACSF_CHAN_HI 4
`define QACSF_CHAN_LO 3
`define QACSF_CHAN_RESET 2'h0

// --------------------------------------------------------------
// Result word
// --------------------------------------------------------------
`define QACSF_RES_W 8

`endif

/* File: hdl/qacsf_buf2.v */
// Two-entry buffer with valid and ready on both sides
// Assumes one clock, active-high synchronous flush, async active-low reset
`include "qacsf_defines.vh"

module qacsf_buf2 (
    clk,
    rst_n,
    flush,
    in_valid,
    in_ready,
    in_data,
    out_valid,
    out_ready,
    out_data
);
    input wire clk;
    input wire rst_n;
    input wire flush;
    input wire in_valid;
    output wire in_ready;
    input wire [`QACSF_RES_W-1:0] in_data;
    output wire out_valid;
    input wire out_ready;
    output wire [`QACSF_RES_W-1:0] out_data;

    reg [`QACSF_RES_W-1:0] mem_r [0:1];
    reg wr_ptr_r;
    reg rd_ptr_r;
    reg [1:0] count_r;
    wire push;
    wire pop;

    assign in_ready = (count_r != 2'h2);
    assign out_valid = (count_r != 2'h0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // --------------------------------------------------------------
    // Storage and pointers
    // --------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
        end else if (flush) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (push && !pop) begin
                count_r <= count_r + 2'h1;
            end else if (pop && !push) begin
                count_r <= count_r - 2'h1;
            end
        end
    end

    always @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

endmodule

/* File: tb/qacsf_top_chk.sv */
// Port checker of the converter serial frame control
// Assumes binding to qacsf_top and a slow serial clock
module qacsf_top_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic frame_sel_n,
    input wire logic ser_clk,
    input wire logic ser_res_out,
    input wire logic ser_res_oe_n,
    input wire logic track_mode,
    input wire logic hold_mode,
    input wire logic power_down,
    input wire logic sample_strobe,
    input wire logic [1:0] chan_sel,
    input wire logic [7:0] ctl_reg
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sclk_q;
    logic [2:0] n_falls;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ----
    // Serial clock falls counted while tracking
    // ----
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q <= 1'b0;
            n_falls <= 3'h0;
        end else begin
            sclk_q <= ser_clk;
            if (!track_mode) begin
                n_falls <= 3'h0;
            end else if (sclk_q && !ser_clk) begin
                n_falls <= n_falls + 3'h1;
            end
        end
    end
    // ----
    // Properties
    // ----
    oe_follow_a: assert property (
        $fell(frame_sel_n) |-> ##[2:4] !ser_res_oe_n) else $error("oe late");
    sel_idle_a: assert property (
        frame_sel_n [*6] |-> power_down && ser_res_oe_n && !track_mode && !hold_mode)
        else $error("busy while deselected");
    modes_excl_a: assert property (
        !(track_mode && hold_mode) && !(power_down && (track_mode || hold_mode)))
        else $error("modes overlap");
    track_len_a: assert property (
        $fell(track_mode) && hold_mode |-> n_falls == 3'h3) else $error("track length");
    capture_point_a: assert property (
        $fell(track_mode) && hold_mode |-> ##[0:1] sample_strobe) else $error("no capture");
    strobe_pulse_a: assert property (
        sample_strobe |=> !sample_strobe) else $error("strobe too long");
    res_quiet_a: assert property (
        (track_mode || power_down) && !ser_res_oe_n |-> !ser_res_out) else $error("out not low");
    chan_change_a: assert property (
        !$stable(chan_sel) |-> $rose(track_mode)) else $error("chan moved");
    chan_source_a: assert property (
        $rose(track_mode) |-> chan_sel == $past(ctl_reg[4:3])) else $error("chan source");
    ctl_load_a: assert property (
        !$stable(ctl_reg) |-> ser_clk && !frame_sel_n) else $error("ctl load time");
endmodule
bind qacsf_top qacsf_top_chk chk_u (.clk(clk), .arst_n(arst_n), .frame_sel_n(frame_sel_n),
    .ser_clk(ser_clk), .ser_res_out(ser_res_out), .ser_res_oe_n(ser_res_oe_n),
    .track_mode(track_mode), .hold_mode(hold_mode), .power_down(power_down),
    .sample_strobe(sample_strobe), .chan_sel(chan_sel), .ctl_reg(ctl_reg));

/* File: tb/qacsf_host_model.sv */
// Host serial master that frames conversions and collects results
// Assumes the bench fills cfg_a before run_frame and reads got_q
module qacsf_host_model (
    input wire logic clk,
    output logic frame_sel_n,
    output logic ser_clk,
    output logic ser_cfg_in,
    input wire logic ser_res_out,
    input wire logic ser_res_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cfg_a [0:7];
    logic [7:0] got_q [$];
    logic pin_q = 1'b0;
    logic dout_w;
    initial begin
        frame_sel_n = 1'b1;
        ser_clk = 1'b0;
        ser_cfg_in = 1'b0;
    end
    // ----
    // Released pin shows no stale level
    // ----
    assign dout_w = ser_res_oe_n ? ~pin_q : ser_res_out;
    always @(posedge clk) if (!ser_res_oe_n) pin_q <= ser_res_out;
    task automatic half();
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic run_frame(input int nrise, input logic idle);
        logic [7:0] word;
        int k;
        word = 8'h00;
        ser_clk = idle;
        half();
        frame_sel_n = 1'b0;
        half();
        for (k = 0; k < nrise; k++) begin
            ser_clk = 1'b0;
            ser_cfg_in = k % 16 < 8 ? cfg_a[k / 16][7 - k % 8] : ~ser_cfg_in;
            half();
            if (k % 16 >= 3 && k % 16 < 11) word = {word[6:0], dout_w};
            if (k % 16 == 10) got_q.push_back(word);
            ser_clk = 1'b1;
            half();
        end
        frame_sel_n = 1'b1;
        half();
    endtask
endmodule

/* File: tb/test_quad_channel_adc_serial_frame_control.sv */
// Self-checking bench of the converter serial frame control
// Assumes the host model and checker are compiled first
module test_quad_channel_adc_serial_frame_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] core_code = 8'hff;
    wire logic frame_sel_n, ser_clk, ser_cfg_in;
    logic ser_res_out, ser_res_oe_n, track_mode, hold_mode, power_down, sample_strobe;
    logic [1:0] chan_sel;
    logic [7:0] ctl_reg;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000_4922;
    logic [31:0] cseed = 32'h0000_4922;
    logic [7:0] exp_q [$];
    logic [1:0] chan_q [$];
    logic [1:0] cur_chan = 2'h0;
    always #10 clk = ~clk;
    qacsf_top dut_u (.clk(clk), .arst_n(arst_n), .frame_sel_n(frame_sel_n), .ser_clk(ser_clk),
        .ser_cfg_in(ser_cfg_in), .core_code(core_code), .ser_res_out(ser_res_out),
        .ser_res_oe_n(ser_res_oe_n), .track_mode(track_mode), .hold_mode(hold_mode),
        .power_down(power_down), .sample_strobe(sample_strobe), .chan_sel(chan_sel),
        .ctl_reg(ctl_reg));
    qacsf_host_model host_u (.clk(clk), .frame_sel_n(frame_sel_n), .ser_clk(ser_clk),
        .ser_cfg_in(ser_cfg_in), .ser_res_out(ser_res_out), .ser_res_oe_n(ser_res_oe_n));
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic reset_dut();
        #1 arst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic frame(input int nrise, input logic idle);
        int i;
        int last;
        last = (nrise + 8) / 16 - 1;
        for (i = 0; i < 8; i++) begin
            seed = next_rand(seed);
            host_u.cfg_a[i] = seed[7:0];
            if (nrise == 64) host_u.cfg_a[i][4:3] = i[1:0];
        end
        for (i = 0; i < (nrise + 12) / 16; i++) begin
            chan_q.push_back(i == 0 ? cur_chan : host_u.cfg_a[i - 1][4:3]);
        end
        host_u.run_frame(nrise, idle);
        if (last >= 0) begin
            cur_chan = host_u.cfg_a[last][4:3];
            check("ctl_reg", ctl_reg, host_u.cfg_a[last]);
        end
        if (nrise % 16 == 0) check("count", 8'(host_u.got_q.size()), 8'(exp_q.size()));
        while (host_u.got_q.size() > 0) begin
            check("result", host_u.got_q.pop_front(), exp_q.pop_front());
        end
        check("oe_n", {7'h00, ser_res_oe_n}, 8'h01);
        exp_q.delete();
        chan_q.delete();
    endtask
    // ----
    // Capture monitor, timeout and sequence
    // ----
    always @(posedge clk) begin
        if (sample_strobe === 1'b1) begin
            exp_q.push_back(core_code);
            check("oe_on", {7'h00, ser_res_oe_n}, 8'h00);
            if (chan_q.size() > 0) begin
                check("chan_sel", {6'h00, chan_sel}, {6'h00, chan_q.pop_front()});
            end else begin
                check("strobe", 8'h01, 8'h00);
            end
            cseed = next_rand(cseed);
            #1 core_code = cseed[7:0];
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        reset_dut();
        frame(16, 1'b0);
        frame(64, 1'b1);
        frame(3, 1'b0);
        frame(8, 1'b1);
        frame(32, 1'b0);
        repeat (6) begin
            seed = next_rand(seed);
            frame(16 * (int'(seed[1:0]) + 1), seed[2]);
        end
        reset_dut();
        cur_chan = 2'h0;
        frame(16, 1'b1);
        complete_run();
    end
endmodule
